// ==== logic/cpb_bus_lanes.sv ====
// module: address, byte enable, data and parity lanes of the cpu bus
`timescale 1ns/1ns
module cpb_bus_lanes
  import cpb_pkg::*;
#(
  parameter int DEPTH = cpb_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,                               // core clock, 50 MHz
  input wire logic sys_rst,                               // sync reset, active high
  input wire logic req_valid,                             // core queues a transfer
  output logic req_ready,                                 // queue has room
  input wire logic req_write,                             // 1 write, 0 read
  input wire logic [cpb_pkg::AW-1:0] req_addr,            // word address
  input wire logic [cpb_pkg::LANES-1:0] req_be_n,         // byte enables, low active
  input wire logic [cpb_pkg::DW-1:0] req_data,            // write data
  output logic rd_valid,                                  // read data pulse
  output logic [cpb_pkg::DW-1:0] rd_data,                 // read data to core
  output logic inval_valid,                               // invalidation pulse
  output logic [cpb_pkg::IW-1:0] inval_addr,              // line address, bits 31:4
  output logic bus_clk,                                   // bus clock out
  input wire logic bus_hold,                              // bus granted away
  input wire logic addr_hold,                             // address hold request
  input wire logic snoop_strobe_n,                        // external address valid
  input wire logic ready_n,                               // cycle end, low active
  input wire logic bs8_n,                                 // 8-bit bus size
  input wire logic bs16_n,                                // 16-bit bus size
  input wire logic [cpb_pkg::AW-1:0] word_address_lines_in,   // address pins in
  output logic [cpb_pkg::AW-1:0] word_address_lines_out,      // address pins out
  output logic word_address_lines_oe,                         // address drive
  output logic [cpb_pkg::LANES-1:0] byte_lane_enable_n,       // byte enables
  output logic byte_lane_enable_oe,                           // byte enable drive
  input wire logic [cpb_pkg::DW-1:0] data_lines_in,           // data pins in
  output logic [cpb_pkg::DW-1:0] data_lines_out,              // data pins out
  output logic data_lines_oe,                                 // data drive
  input wire logic [cpb_pkg::LANES-1:0] lane_parity_bits_in,  // parity pins in
  output logic [cpb_pkg::LANES-1:0] lane_parity_bits_out,     // parity pins out
  output logic lane_parity_bits_oe,                           // parity drive
  output logic parity_error_n                                 // read parity error
);
  import cpb_pkg::*;

  typedef struct packed {
    logic div;
    cpb_state_t st;
    logic wr;
    logic [AW-1:0] addr;
    logic [LANES-1:0] be_n;
    logic [DW-1:0] wdata;
    logic [LANES-1:0] wpar;
    logic addr_oe;
    logic be_oe;
    logic data_oe;
    logic perr_n;
    logic [DW-1:0] rdata;
    logic rvalid;
    logic [IW-1:0] iaddr;
    logic ivalid;
  } cpb_st_t;

  localparam cpb_st_t RST_VAL = '{
    div: 1'b0, st: ST_IDLE, wr: 1'b0, addr: '0, be_n: BE_NONE_N,
    wdata: '0, wpar: '0, addr_oe: 1'b0, be_oe: 1'b0, data_oe: 1'b0,
    perr_n: PERR_IDLE_N, rdata: '0, rvalid: 1'b0, iaddr: '0, ivalid: 1'b0
  };

  cpb_st_t r;
  cpb_st_t next_r;

  // request queue between the core and the bus sequencer
  cpb_stream_if #(.W(REQ_W)) q_in ();
  cpb_stream_if #(.W(REQ_W)) q_out ();

  assign q_in.valid = req_valid;
  assign q_in.data = {req_write, req_addr, req_be_n, req_data};
  assign req_ready = q_in.ready;

  cpb_fifo #(.W(REQ_W), .DEPTH(DEPTH)) u_queue (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_s(q_in),
    .out_s(q_out)
  );

  // bus rate: one core cycle in two is a bus clock edge
  logic bus_ce;
  assign bus_ce = r.div;
  assign bus_clk = ~r.div;  // rises on the edge that closes a bus_ce cycle

  // fields of the head request
  logic [DW-1:0] head_data;
  logic [LANES-1:0] head_be_n;
  logic [AW-1:0] head_addr;
  logic head_wr;
  assign head_data = q_out.data[REQ_DATA_LSB +: DW];
  assign head_be_n = q_out.data[REQ_BE_LSB +: LANES];
  assign head_addr = q_out.data[REQ_ADDR_LSB +: AW];
  assign head_wr = q_out.data[REQ_WR_BIT];

  // a new cycle starts only at a bus edge, idle, and not in hold
  logic start;
  assign start = bus_ce && (r.st == ST_IDLE) && !bus_hold && q_out.valid;
  assign q_out.ready = start;

  // write parity is made once at issue so pins stay stable
  logic [LANES-1:0] gen_par;
  cpb_lane_parity #(.LANES(LANES)) u_gen (
    .data(head_data),
    .par_in('0),
    .mask('0),
    .par_out(gen_par),
    .err()
  );

  // read check; a narrow bus shrinks the lanes that count
  logic [LANES-1:0] chk_mask;
  logic chk_err;
  assign chk_mask = ~r.be_n & cpb_size_mask(bs8_n, bs16_n);
  cpb_lane_parity #(.LANES(LANES)) u_chk (
    .data(data_lines_in),
    .par_in(lane_parity_bits_in),
    .mask(chk_mask),
    .par_out(),
    .err(chk_err)
  );

  // the sampled end of a read or a write transfer
  logic rd_done;
  logic wr_done;
  assign rd_done = bus_ce && (r.st == ST_DATA) && !r.wr && !ready_n;
  assign wr_done = bus_ce && (r.st == ST_DATA) && r.wr && !ready_n;

  // sequencer and pin state; hold is only honoured between cycles,
  // since the partner grants it only once a cycle has finished
  always_comb begin
    next_r = r;
    next_r.div = ~r.div;
    next_r.rvalid = 1'b0;
    next_r.ivalid = 1'b0;
    if (bus_ce) begin
      // drives follow hold at the next bus edge
      next_r.addr_oe = !(bus_hold || addr_hold);
      next_r.be_oe = !bus_hold;
      // status lasts exactly the bus clock after ready
      next_r.perr_n = !(rd_done && chk_err);
      // external address sampled while the address pins are released
      // our own address still on the pins would be taken for the snoop address
      if (addr_hold && !snoop_strobe_n && !r.addr_oe) begin
        next_r.iaddr = word_address_lines_in[AW-1:INV_LSB];
        next_r.ivalid = 1'b1;
      end
      unique case (r.st)
        ST_IDLE: begin
          if (start) begin
            next_r.wr = head_wr;
            next_r.addr = head_addr;
            next_r.be_n = head_be_n;
            next_r.wdata = head_data;
            next_r.wpar = gen_par;
            next_r.st = ST_ADDR;
          end
        end
        ST_ADDR: begin
          // first clock carries only address; data follows
          next_r.data_oe = r.wr;
          next_r.st = ST_DATA;
        end
        ST_DATA: begin
          if (!ready_n) begin
            next_r.data_oe = 1'b0;
            if (!r.wr) begin
              // data goes up whatever its parity says
              next_r.rdata = data_lines_in;
              next_r.rvalid = 1'b1;
            end
            next_r.st = ST_IDLE;
          end
        end
        default: begin
          next_r.st = ST_IDLE;
        end
      endcase
    end
  end

  // reset releases the data and parity pins and idles the status
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= RST_VAL;
    end else begin
      r <= next_r;
    end
  end

  // pins and core-side outputs straight from state
  assign word_address_lines_out = r.addr;
  assign word_address_lines_oe = r.addr_oe;
  assign byte_lane_enable_n = r.be_n;
  assign byte_lane_enable_oe = r.be_oe;
  assign data_lines_out = r.wdata;
  assign data_lines_oe = r.data_oe;
  assign lane_parity_bits_out = r.wpar;
  assign lane_parity_bits_oe = r.data_oe;  // same timing as data
  assign parity_error_n = r.perr_n;  // never floated
  assign rd_valid = r.rvalid;
  assign rd_data = r.rdata;
  assign inval_valid = r.ivalid;
  assign inval_addr = r.iaddr;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_bus_rate: assert property (bus_ce |=> !bus_ce ##1 bus_ce)
    else $error("bus enable is not every second core clock");
  chk_addr_float: assert property (bus_ce && (bus_hold || addr_hold) |=> !word_address_lines_oe)
    else $error("address lines driven during hold");
  chk_be_float: assert property (bus_ce && bus_hold |=> !byte_lane_enable_oe)
    else $error("byte enables driven during bus hold");
  chk_data_late: assert property ($rose(data_lines_oe) |-> $past(r.st) == ST_ADDR && r.st == ST_DATA)
    else $error("write data driven in the first clock");
  chk_data_hold: assert property (wr_done |-> data_lines_oe ##1 !data_lines_oe)
    else $error("write data not held to the cycle end");
  chk_par_even: assert property (lane_parity_bits_oe |->
    (lane_parity_bits_out[0] ^ (^data_lines_out[7:0])) == 1'b0
    && (lane_parity_bits_out[1] ^ (^data_lines_out[15:8])) == 1'b0
    && (lane_parity_bits_out[2] ^ (^data_lines_out[23:16])) == 1'b0
    && (lane_parity_bits_out[3] ^ (^data_lines_out[31:24])) == 1'b0)
    else $error("write parity not even");
  chk_perr_cause: assert property ($fell(parity_error_n) |-> $past(rd_done) && $past(chk_err))
    else $error("parity error without a failing read");
  chk_perr_width: assert property ($fell(parity_error_n) |-> !parity_error_n [*2] ##1 parity_error_n)
    else $error("parity error not one bus clock wide");
  chk_perr_report: assert property (rd_done && chk_err |=> !parity_error_n)
    else $error("detected parity error not reported");
  chk_perr_mask: assert property (rd_done && ((~r.be_n & cpb_size_mask(bs8_n, bs16_n)) == 4'h0)
    |=> parity_error_n)
    else $error("parity error flagged with no lane enabled");
  chk_rdata_kept: assert property (rd_done |=> rd_valid && rd_data == $past(data_lines_in))
    else $error("read data altered or lost");
  chk_reset_quiet: assert property ($fell(sys_rst) |->
    parity_error_n && !data_lines_oe && !lane_parity_bits_oe)
    else $error("pins active right after reset");

  cov_write_done: cover property (wr_done);
  cov_read_perr: cover property (rd_done && chk_err);
  cov_invalidate: cover property (inval_valid);
  cov_queue_full: cover property (req_valid && !req_ready);
endmodule

// ==== shared/cpb_pkg.sv ====
// package: constants, states and helpers for the cpu bus lanes block
package cpb_pkg;
  localparam int DW = 32;            // data lane width
  localparam int LANES = 4;          // byte lanes
  localparam int AW = 30;            // word address width (bits 31:2)
  localparam int IW = 28;            // invalidation address width (bits 31:4)
  localparam int INV_LSB = 2;        // bit 4 of the byte address in the word address
  localparam int CORE_PER_BUS = 2;   // core clocks per bus clock
  localparam int FIFO_DEPTH = 4;     // request queue depth
  localparam int REQ_W = 1 + AW + LANES + DW;
  // request word field positions
  localparam int REQ_DATA_LSB = 0;
  localparam int REQ_BE_LSB = DW;
  localparam int REQ_ADDR_LSB = DW + LANES;
  localparam int REQ_WR_BIT = DW + LANES + AW;
  // reset values and the all-lanes mask
  localparam logic PERR_IDLE_N = 1'b1;
  localparam logic [LANES-1:0] BE_NONE_N = 4'hf;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } cpb_state_t;

  // lanes a narrow bus really returns on a read
  function automatic logic [LANES-1:0] cpb_size_mask(input logic bs8_n, input logic bs16_n);
    cpb_size_mask = !bs8_n ? 4'h1 : (!bs16_n ? 4'h3 : LANES_ALL);
  endfunction
endpackage

// ==== shared/cpb_stream_if.sv ====
// interface: valid/ready word stream between the block's own modules
`timescale 1ns/1ns
interface cpb_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== logic/cpb_fifo.sv ====
// module: small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
module cpb_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,  // core clock
  input wire logic sys_rst,  // sync reset, active high
  cpb_stream_if.snk in_s,    // filling side
  cpb_stream_if.src out_s    // draining side
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } cpb_fifo_st_t;

  cpb_fifo_st_t r;
  cpb_fifo_st_t next_r;
  logic push;
  logic pop;

  // full and empty come straight from the count
  assign in_s.ready = (r.cnt != FULL_CNT);
  assign out_s.valid = (r.cnt != '0);
  assign out_s.data = r.mem[r.rp];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // pointers wrap only on a power-of-two depth
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_s.data;
      next_r.wp = r.wp + 1'b1;
    end
    if (pop) begin
      next_r.rp = r.rp + 1'b1;
    end
    next_r.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  chk_fifo_no_overflow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    r.cnt == FULL_CNT |-> !in_s.ready) else $error("fifo accepts while full");
endmodule

// ==== logic/cpb_lane_parity.sv ====
// module: per-lane even parity generation and masked checking
`timescale 1ns/1ns
module cpb_lane_parity #(
  parameter int LANES = 4
) (
  input wire logic [LANES*8-1:0] data,   // data lanes
  input wire logic [LANES-1:0] par_in,   // received parity bits
  input wire logic [LANES-1:0] mask,     // lanes taking part in the check
  output logic [LANES-1:0] par_out,      // generated parity bits
  output logic err                       // any enabled lane mismatched
);
  logic [LANES-1:0] bad;

  // each bit makes its byte plus itself hold an even number of ones
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign par_out[i] = ^data[i*8 +: 8];
    assign bad[i] = (par_out[i] != par_in[i]) && mask[i];
  end
  assign err = |bad;
endmodule

// ==== verification/cpb_tb_pkg.sv ====
// bench helpers: read answer pattern and per-lane even parity
package cpb_tb_pkg;
  import cpb_pkg::*;
  // answer word depends on the address so a wrong address cannot pass
  function automatic logic [DW-1:0] cpb_pattern(input logic [AW-1:0] a);
    cpb_pattern = {2'h1, a} ^ 32'h5a3c_96e1;
  endfunction
  // lane i covers bits 8i+7:8i; the bit makes the lane's count of ones even
  function automatic logic [LANES-1:0] cpb_par4(input logic [DW-1:0] d);
    for (int i = 0; i < LANES; i++) cpb_par4[i] = ^d[8*i +: 8];
  endfunction
endpackage

// ==== verification/cpb_sys_model.sv ====
// partner model: system bus controller answering reads with even parity
`timescale 1ns/1ns
module cpb_sys_model
  import cpb_pkg::*;
(
  input wire logic bus_clk,                       // bus clock from the device
  input wire logic slow,                          // answer one bus clock in three
  input wire logic [cpb_pkg::LANES-1:0] corrupt,  // lanes sent with bad parity
  input wire logic [cpb_pkg::AW-1:0] addr,        // address the device drives
  output logic ready_n,                           // cycle end, low active
  output logic [cpb_pkg::DW-1:0] data,            // read data lines
  output logic [cpb_pkg::LANES-1:0] par           // read parity lines
);
  import cpb_tb_pkg::*;
  int cnt = 0;
  initial begin
    ready_n = 1'b1;
    data = '0;
    par = '0;
  end
  // answers change just after the bus clock edge and hold until the next one
  always @(posedge bus_clk) begin
    #1;
    cnt = (cnt + 1) % 3;
    if (!slow || cnt == 0) begin
      ready_n = 1'b0;
      data = cpb_pattern(addr);
      par = cpb_par4(data) ^ corrupt;
    end else begin
      // released lines show an inverted pattern so a stale value cannot pass
      ready_n = 1'b1;
      data = ~data;
      par = ~par;
    end
  end
endmodule

// ==== verification/cpb_bus_lanes_test.sv ====
// testbench: writes, reads with parity faults, hold, snoop and queue scenarios
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module cpb_bus_lanes_test;
  import cpb_pkg::*;
  import cpb_tb_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, slow = 1'b0, saw_full = 1'b0;
  logic bus_hold = 1'b0, addr_hold = 1'b0, snoop_strobe_n = 1'b1, bs8_n = 1'b1, bs16_n = 1'b1;
  logic [AW-1:0] req_addr = '0, tb_addr = '1;
  logic [LANES-1:0] req_be_n = 4'hf, corrupt = 4'h0;
  logic [DW-1:0] req_data = '0;
  logic req_ready, rd_valid, inval_valid, bus_clk, ready_n, parity_error_n;
  logic word_address_lines_oe, byte_lane_enable_oe, data_lines_oe, lane_parity_bits_oe;
  logic [DW-1:0] rd_data, data_lines_out, m_data, data_pins;
  logic [IW-1:0] inval_addr;
  logic [AW-1:0] word_address_lines_out, addr_pins;
  logic [LANES-1:0] byte_lane_enable_n, lane_parity_bits_out, m_par, par_pins;
  int mismatches = 0, checks_done = 0, cycles = 0;
  // pin levels: whoever enables its driver sets the wire
  assign data_pins = data_lines_oe ? data_lines_out : m_data;
  assign par_pins = lane_parity_bits_oe ? lane_parity_bits_out : m_par;
  assign addr_pins = word_address_lines_oe ? word_address_lines_out : tb_addr;
  cpb_bus_lanes #(.DEPTH(FIFO_DEPTH)) dut_u (
    .clk_sys, .sys_rst, .req_valid, .req_ready, .req_write, .req_addr, .req_be_n, .req_data,
    .rd_valid, .rd_data, .inval_valid, .inval_addr, .bus_clk, .bus_hold, .addr_hold,
    .snoop_strobe_n, .ready_n, .bs8_n, .bs16_n, .word_address_lines_in(addr_pins),
    .word_address_lines_out, .word_address_lines_oe, .byte_lane_enable_n, .byte_lane_enable_oe,
    .data_lines_in(data_pins), .data_lines_out, .data_lines_oe, .lane_parity_bits_in(par_pins),
    .lane_parity_bits_out, .lane_parity_bits_oe, .parity_error_n
  );
  cpb_sys_model sys_u (.bus_clk, .slow, .corrupt, .addr(word_address_lines_out), .ready_n,
    .data(m_data), .par(m_par));
  // 50 MHz core clock
  always #10 clk_sys = ~clk_sys;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // a hang counts as a mismatch; all scenarios fit well inside this
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // every input moves 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // request held until the edge that sees ready; caller drops valid afterwards
  task automatic send_req(input logic w, input logic [AW-1:0] a, input logic [LANES-1:0] be,
                          input logic [DW-1:0] d);
    {req_valid, req_write, req_addr, req_be_n, req_data} = {1'b1, w, a, be, d};
    for (int n = 0; req_ready !== 1'b1 && n < 500; n++) begin
      saw_full = 1'b1;
      step(1);
    end
    step(1);
  endtask
  task automatic wait_rd(output logic [DW-1:0] got);
    for (int n = 0; rd_valid !== 1'b1 && n < 300; n++) step(1);
    `CHK(rd_valid, 1'b1)
    got = rd_data;
  endtask
  task automatic t_write(input logic [AW-1:0] a, input logic [LANES-1:0] be, input logic [DW-1:0] d);
    send_req(1'b1, a, be, d);
    req_valid = 1'b0;
    for (int n = 0; data_lines_oe !== 1'b1 && n < 50; n++) step(1);
    `CHK(byte_lane_enable_n, be)
    `CHK({byte_lane_enable_oe, word_address_lines_out}, {1'b1, a})
    // data and parity stand through every clock until the cycle ends
    for (int n = 0; data_lines_oe === 1'b1 && n < 50; n++) begin
      `CHK(data_lines_out, d)
      `CHK({lane_parity_bits_oe, lane_parity_bits_out}, {1'b1, cpb_par4(d)})
      `CHK(parity_error_n, 1'b1)
      step(1);
    end
    `CHK(lane_parity_bits_oe, 1'b0)
    done("write");
  endtask
  task automatic t_read(input logic [AW-1:0] a, input logic [LANES-1:0] be, input logic [LANES-1:0] bad,
                        input logic b8, input logic b16, input logic err);
    logic [DW-1:0] got;
    {corrupt, bs8_n, bs16_n} = {bad, b8, b16};
    send_req(1'b0, a, be, 32'h0000_0000);
    req_valid = 1'b0;
    wait_rd(got);
    `CHK(got, cpb_pattern(a))
    `CHK(parity_error_n, ~err)
    step(1);
    `CHK(parity_error_n, ~err)
    step(1);
    `CHK(parity_error_n, 1'b1)
    {corrupt, bs8_n, bs16_n} = {4'h0, 1'b1, 1'b1};
    done("read");
  endtask
  task automatic t_hold();
    logic [DW-1:0] got;
    logic seen;
    seen = 1'b0;
    bus_hold = 1'b1;
    step(4);
    `CHK({word_address_lines_oe, byte_lane_enable_oe}, 2'b00)
    send_req(1'b0, 30'h0000_0200, 4'h0, 32'h0000_0000);
    req_valid = 1'b0;
    for (int n = 0; n < 20; n++) begin
      seen = seen | rd_valid;
      step(1);
    end
    `CHK(seen, 1'b0)
    bus_hold = 1'b0;
    wait_rd(got);
    `CHK(got, cpb_pattern(30'h0000_0200))
    done("hold");
  endtask
  task automatic t_snoop(input logic [AW-1:0] a);
    {addr_hold, snoop_strobe_n, tb_addr} = {1'b1, 1'b0, a};
    for (int n = 0; inval_valid !== 1'b1 && n < 10; n++) step(1);
    `CHK({inval_valid, inval_addr}, {1'b1, a[AW-1:INV_LSB]})
    `CHK(word_address_lines_oe, 1'b0)
    {addr_hold, snoop_strobe_n, tb_addr} = {1'b0, 1'b1, ~a};
    step(2);
    done("snoop");
  endtask
  // six reads against a slow partner: the queue must refuse, then drain in order
  task automatic t_fifo();
    logic [DW-1:0] got;
    {saw_full, slow} = 2'b01;
    fork
      begin
        for (int i = 0; i < 6; i++) send_req(1'b0, 30'h0000_0300 | 30'(i), 4'h0, 32'h0000_0000);
        req_valid = 1'b0;
      end
      for (int i = 0; i < 6; i++) begin
        wait_rd(got);
        `CHK(got, cpb_pattern(30'h0000_0300 | 30'(i)))
        step(1);
      end
    join
    `CHK({saw_full, req_ready}, 2'b11)
    slow = 1'b0;
    done("fifo");
  endtask
  // main sequence: reset for 10 cycles, then each scenario in turn
  initial begin
    step(5);
    `CHK({data_lines_oe, lane_parity_bits_oe, parity_error_n}, 3'b001)
    step(5);
    sys_rst = 1'b0;
    t_write(30'h0000_0040, 4'h0, 32'h8001_ff7e);
    t_write(30'h0000_0041, 4'h9, 32'h0102_0304);
    slow = 1'b1;
    t_write(30'h3fff_fffe, 4'h0, 32'hfe7f_0180);
    slow = 1'b0;
    t_read(30'h0000_0101, 4'h0, 4'h0, 1'b1, 1'b1, 1'b0);
    t_read(30'h0000_0102, 4'h0, 4'h4, 1'b1, 1'b1, 1'b1);
    t_read(30'h0000_0103, 4'h4, 4'h4, 1'b1, 1'b1, 1'b0);
    t_read(30'h0000_0104, 4'h0, 4'h2, 1'b0, 1'b1, 1'b0);
    t_read(30'h0000_0105, 4'h0, 4'h2, 1'b1, 1'b0, 1'b1);
    t_read(30'h0000_0106, 4'h0, 4'h4, 1'b1, 1'b0, 1'b0);
    t_read(30'h0000_0107, 4'h0, 4'h8, 1'b1, 1'b1, 1'b1);
    t_read(30'h0000_0108, 4'hf, 4'hf, 1'b1, 1'b1, 1'b0);
    t_hold();
    t_snoop(30'h2abc_def4);
    t_fifo();
    give_verdict();
  end
endmodule
